//--- rtl/scb_pkg.sv
// Constants, field layout and carrier types of the system configuration bank.
// Assumes a single clock mclk and an APB slave port with byte addresses.
// =====================================================================
// Operation
// - Each core has its own mask choosing which interrupt lines raise its NMI.
// - Each core has a writable debug instance identifier driven to its debug port.
// - Each core's halted state is readable by software.
// - A skip bit of one routes that pin around its input synchroniser.
// - A skipped pin reaches the input register two cycles sooner.
// - The low skip register at 0x0C covers pins 0 to 29.
// - The high skip register at 0x10 covers pins 30 to 35.
// - The override register at 0x14 lets software drive either core's debug port.
// - One core may thereby drive the other core's debug port.
// - A set bit in the register at 0x18 powers down its memory.
// - Each memory has its own power-down bit.
// - The bank sits at base 0x40004000; core masks at 0x00 and 0x04.
// - The processor configuration register sits at offset 0x08.
// - Mask bit n enables the NMI from interrupt line n.
// - An attach bit links the core's port to the bank and cuts the pads.
// - Halted bits are read only, bit 0 core 0, bit 1 core 1, reset zero.
package scb_pkg;

  // =====================================================================
  // Address map
  localparam logic [31:0] BANK_BASE = 32'h40004000;
  localparam logic [11:0] OFF_NMI_MASK0 = 12'h000;
  localparam logic [11:0] OFF_NMI_MASK1 = 12'h004;
  localparam logic [11:0] OFF_PROC_CFG = 12'h008;
  localparam logic [11:0] OFF_SKIP_LOW = 12'h00C;
  localparam logic [11:0] OFF_SKIP_HIGH = 12'h010;
  localparam logic [11:0] OFF_DBG_OVR = 12'h014;
  localparam logic [11:0] OFF_MEM_OFF = 12'h018;

  // =====================================================================
  // Field positions
  localparam int ID1_LSB = 28;
  localparam int ID0_LSB = 24;
  localparam int HALT1_BIT = 1;
  localparam int HALT0_BIT = 0;
  localparam int DBG1_ATTACH = 7;
  localparam int DBG1_SWCLK = 6;
  localparam int DBG1_SWDI = 5;
  localparam int DBG1_SWDO = 4;
  localparam int DBG0_ATTACH = 3;
  localparam int DBG0_SWCLK = 2;
  localparam int DBG0_SWDI = 1;
  localparam int DBG0_SWDO = 0;
  localparam int LOW_PINS = 30;
  localparam int HIGH_PINS = 6;

  // =====================================================================
  // Writable bits and reset values
  localparam logic [31:0] PROC_CFG_WMASK = 32'hFF000000;
  localparam logic [31:0] SKIP_LOW_WMASK = 32'h3FFFFFFF;
  localparam logic [31:0] SKIP_HIGH_WMASK = 32'h0000003F;
  localparam logic [31:0] DBG_OVR_WMASK = 32'h000000EE;
  localparam logic [31:0] NMI_MASK_RESET = 32'h00000000;
  localparam logic [3:0] ID1_RESET = 4'h1;
  localparam logic [3:0] ID0_RESET = 4'h0;
  localparam logic [31:0] SKIP_RESET = 32'h00000000;
  localparam logic [31:0] DBG_OVR_RESET = 32'h00000066;
  localparam logic [31:0] MEM_OFF_RESET = 32'h00000000;

  // =====================================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scb_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } scb_apb_rsp_type;

  typedef struct packed {
    logic [31:0] nmi_mask0;
    logic [31:0] nmi_mask1;
    logic [31:0] proc_cfg;
    logic [31:0] skip_low;
    logic [31:0] skip_high;
    logic [31:0] dbg_ovr;
    logic [31:0] mem_off;
  } scb_regs_type;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_NMI0 = 3'b001,
    SEL_NMI1 = 3'b010,
    SEL_CFG = 3'b011,
    SEL_SKIPL = 3'b100,
    SEL_SKIPH = 3'b101,
    SEL_DBG = 3'b110,
    SEL_MEM = 3'b111
  } scb_sel_type;

  // Decoding is shared by the read and the write paths.
  function automatic scb_sel_type scb_decode(input logic [11:0] addr);
    scb_sel_type sel;
    sel = SEL_NONE;
    if (addr == OFF_NMI_MASK0) begin
      sel = SEL_NMI0;
    end else if (addr == OFF_NMI_MASK1) begin
      sel = SEL_NMI1;
    end else if (addr == OFF_PROC_CFG) begin
      sel = SEL_CFG;
    end else if (addr == OFF_SKIP_LOW) begin
      sel = SEL_SKIPL;
    end else if (addr == OFF_SKIP_HIGH) begin
      sel = SEL_SKIPH;
    end else if (addr == OFF_DBG_OVR) begin
      sel = SEL_DBG;
    end else if (addr == OFF_MEM_OFF) begin
      sel = SEL_MEM;
    end
    return sel;
  endfunction : scb_decode

endpackage : scb_pkg

//--- rtl/scb_in_sync.sv
// Input synchronisers with per-pin skip, feeding the core-side input register.
// Assumes pins may be asynchronous to mclk unless software skips them.
module scb_in_sync #(
  parameter int PINS = 36
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] skip,
  output logic [PINS-1:0] io_in
);

  // =====================================================================
  // Two stages, then the input register
  logic [PINS-1:0] stage1;
  logic [PINS-1:0] stage2;
  logic [PINS-1:0] next_io_in;

  always_comb begin
    // The first stage is never looked at here; only stage2 or the raw pin.
    next_io_in = (skip & pin_in) | (~skip & stage2);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      io_in <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      io_in <= next_io_in;
    end
  end

endmodule : scb_in_sync

//--- rtl/scb_bank.sv
// System configuration bank: NMI masks, debug identifiers and halted status,
// input synchroniser skip, debug port override and memory power-down.
// Assumes an APB master on mclk and core-side signals synchronous to mclk.
//
// Chosen here: register access over APB.
module scb_bank #(
  parameter int IRQ_LINES = 32,
  parameter int MEM_COUNT = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire scb_pkg::scb_apb_req_type apb_req,
  output scb_pkg::scb_apb_rsp_type apb_rsp,
  input wire logic [IRQ_LINES-1:0] irq_lines,
  output logic nmi_core0,
  output logic nmi_core1,
  output logic [3:0] core0_debug_instance_id,
  output logic [3:0] core1_debug_instance_id,
  input wire logic core0_halted,
  input wire logic core1_halted,
  input wire logic [35:0] gpio_pin_in,
  output logic [35:0] core_io_block_in,
  input wire logic [1:0] pad_swclk,
  input wire logic [1:0] pad_swdi,
  input wire logic [1:0] core_swdo,
  output logic [1:0] core_swclk,
  output logic [1:0] core_swdi,
  output logic [1:0] pad_swdo,
  output logic [MEM_COUNT-1:0] memory_power_off
);

  import scb_pkg::*;

  // =====================================================================
  // Declarations
  scb_regs_type regs;
  scb_regs_type next_regs;
  scb_apb_rsp_type next_apb_rsp;
  scb_sel_type read_sel;
  scb_sel_type write_sel;
  logic write_strobe;
  logic [31:0] read_value;
  logic [1:0] halted;
  logic [1:0] next_halted;
  logic [1:0] swdo_seen;
  logic [1:0] next_swdo_seen;
  logic next_nmi_core0;
  logic next_nmi_core1;
  logic [1:0] next_core_swclk;
  logic [1:0] next_core_swdi;
  logic [1:0] next_pad_swdo;
  logic [1:0] attach;
  logic [35:0] skip_all;

  // =====================================================================
  // Bus decode
  always_comb begin
    read_sel = scb_decode(apb_req.paddr);
    write_sel = scb_decode(apb_req.paddr);
    write_strobe = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
  end

  // =====================================================================
  // Read multiplexer
  always_comb begin
    read_value = 32'h00000000;
    if (read_sel == SEL_NMI0) begin
      read_value = regs.nmi_mask0;
    end else if (read_sel == SEL_NMI1) begin
      read_value = regs.nmi_mask1;
    end else if (read_sel == SEL_CFG) begin
      read_value = regs.proc_cfg & PROC_CFG_WMASK;
      read_value[HALT0_BIT] = halted[0];
      read_value[HALT1_BIT] = halted[1];
    end else if (read_sel == SEL_SKIPL) begin
      read_value = regs.skip_low & SKIP_LOW_WMASK;
    end else if (read_sel == SEL_SKIPH) begin
      read_value = regs.skip_high & SKIP_HIGH_WMASK;
    end else if (read_sel == SEL_DBG) begin
      read_value = regs.dbg_ovr & DBG_OVR_WMASK;
      read_value[DBG0_SWDO] = swdo_seen[0];
      read_value[DBG1_SWDO] = swdo_seen[1];
    end else if (read_sel == SEL_MEM) begin
      read_value = 32'h00000000;
      read_value[MEM_COUNT-1:0] = regs.mem_off[MEM_COUNT-1:0];
    end
  end

  // =====================================================================
  // APB response
  always_comb begin
    next_apb_rsp = apb_rsp;
    // Ready rises for exactly one access cycle after each setup cycle.
    next_apb_rsp.pready = apb_req.psel & ~apb_req.penable;
    next_apb_rsp.pslverr = 1'b0;
    if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
      next_apb_rsp.prdata = read_value;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp <= next_apb_rsp;
    end
  end

  // =====================================================================
  // Register writes
  always_comb begin
    next_regs = regs;
    if (write_strobe) begin
      if (write_sel == SEL_NMI0) begin
        next_regs.nmi_mask0 = apb_req.pwdata;
      end else if (write_sel == SEL_NMI1) begin
        next_regs.nmi_mask1 = apb_req.pwdata;
      end else if (write_sel == SEL_CFG) begin
        next_regs.proc_cfg = apb_req.pwdata & PROC_CFG_WMASK;
      end else if (write_sel == SEL_SKIPL) begin
        next_regs.skip_low = apb_req.pwdata & SKIP_LOW_WMASK;
      end else if (write_sel == SEL_SKIPH) begin
        next_regs.skip_high = apb_req.pwdata & SKIP_HIGH_WMASK;
      end else if (write_sel == SEL_DBG) begin
        next_regs.dbg_ovr = apb_req.pwdata & DBG_OVR_WMASK;
      end else if (write_sel == SEL_MEM) begin
        next_regs.mem_off = 32'h00000000;
        next_regs.mem_off[MEM_COUNT-1:0] = apb_req.pwdata[MEM_COUNT-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regs.nmi_mask0 <= NMI_MASK_RESET;
      regs.nmi_mask1 <= NMI_MASK_RESET;
      regs.proc_cfg <= {ID1_RESET, ID0_RESET, 24'h000000};
      regs.skip_low <= SKIP_RESET;
      regs.skip_high <= SKIP_RESET;
      regs.dbg_ovr <= DBG_OVR_RESET;
      regs.mem_off <= MEM_OFF_RESET;
    end else begin
      regs <= next_regs;
    end
  end

  // =====================================================================
  // Status sampling
  always_comb begin
    next_halted = {core1_halted, core0_halted};
    next_swdo_seen = core_swdo;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      halted <= 2'b00;
      swdo_seen <= 2'b00;
    end else begin
      halted <= next_halted;
      swdo_seen <= next_swdo_seen;
    end
  end

  // =====================================================================
  // NMI generation
  always_comb begin
    // Line n reaches the NMI only through mask bit n.
    next_nmi_core0 = |(irq_lines & regs.nmi_mask0[IRQ_LINES-1:0]);
    next_nmi_core1 = |(irq_lines & regs.nmi_mask1[IRQ_LINES-1:0]);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nmi_core0 <= 1'b0;
      nmi_core1 <= 1'b0;
    end else begin
      nmi_core0 <= next_nmi_core0;
      nmi_core1 <= next_nmi_core1;
    end
  end

  // =====================================================================
  // Debug identifiers and port override
  always_comb begin
    attach[0] = regs.dbg_ovr[DBG0_ATTACH];
    attach[1] = regs.dbg_ovr[DBG1_ATTACH];
    // Attached ports take the bank's levels and ignore the pads.
    next_core_swclk[0] = attach[0] ? regs.dbg_ovr[DBG0_SWCLK] : pad_swclk[0];
    next_core_swclk[1] = attach[1] ? regs.dbg_ovr[DBG1_SWCLK] : pad_swclk[1];
    next_core_swdi[0] = attach[0] ? regs.dbg_ovr[DBG0_SWDI] : pad_swdi[0];
    next_core_swdi[1] = attach[1] ? regs.dbg_ovr[DBG1_SWDI] : pad_swdi[1];
    // An attached pad sees an idle high level rather than the core.
    next_pad_swdo[0] = attach[0] ? 1'b1 : core_swdo[0];
    next_pad_swdo[1] = attach[1] ? 1'b1 : core_swdo[1];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      core_swclk <= 2'b11;
      core_swdi <= 2'b11;
      pad_swdo <= 2'b11;
      core0_debug_instance_id <= ID0_RESET;
      core1_debug_instance_id <= ID1_RESET;
    end else begin
      core_swclk <= next_core_swclk;
      core_swdi <= next_core_swdi;
      pad_swdo <= next_pad_swdo;
      core0_debug_instance_id <= regs.proc_cfg[ID0_LSB +: 4];
      core1_debug_instance_id <= regs.proc_cfg[ID1_LSB +: 4];
    end
  end

  // =====================================================================
  // Memory power-down
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      memory_power_off <= '0;
    end else begin
      memory_power_off <= regs.mem_off[MEM_COUNT-1:0];
    end
  end

  // =====================================================================
  // Input synchronisers
  always_comb begin
    skip_all = {regs.skip_high[HIGH_PINS-1:0], regs.skip_low[LOW_PINS-1:0]};
  end

  // Skipping saves two cycles but lets metastable levels into the cores.
  scb_in_sync #(
    .PINS(36)
  ) u_in_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in(gpio_pin_in),
    .skip(skip_all),
    .io_in(core_io_block_in)
  );

endmodule : scb_bank

//--- tb/scb_bank_props.sv
// Port assertions for the system configuration bank.
// Assumes one clock mclk and an APB master that keeps the handshake.
// =====================================================================
// Checker
module scb_bank_props #(
  parameter int IRQ_LINES = 32,
  parameter int MEM_COUNT = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire scb_pkg::scb_apb_req_type apb_req,
  input wire scb_pkg::scb_apb_rsp_type apb_rsp,
  input wire logic [IRQ_LINES-1:0] irq_lines,
  input wire logic nmi_core0,
  input wire logic nmi_core1,
  input wire logic [3:0] core0_debug_instance_id,
  input wire logic [1:0] core_swdo,
  input wire logic [1:0] pad_swdo,
  input wire logic [35:0] gpio_pin_in,
  input wire logic [35:0] core_io_block_in,
  input wire logic [MEM_COUNT-1:0] memory_power_off
);
  import scb_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic setup;
  logic wr_acc;
  logic cfg_wr;
  logic mem_wr;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  // The register lands at the access edge and its output one edge later, hence depth 2.
  assign cfg_wr = wr_acc && apb_req.paddr == OFF_PROC_CFG;
  assign mem_wr = wr_acc && apb_req.paddr == OFF_MEM_OFF;
  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_no_slave_error: assert property (!apb_rsp.pslverr)
    else $error("slave error raised");
  a_unmapped_reads_zero: assert property (setup && !apb_req.pwrite
    && apb_req.paddr == 12'h01C |=> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  a_nmi_needs_irq: assert property (irq_lines == '0 |=> !nmi_core0 && !nmi_core1)
    else $error("nmi without interrupt line");
  a_id_by_write: assert property (!$stable(core0_debug_instance_id)
    |-> $past(cfg_wr, 2))
    else $error("identifier changed without write");
  a_power_by_write: assert property (!$stable(memory_power_off)
    |-> $past(mem_wr, 2))
    else $error("power-down changed without write");
  a_pad_from_core: assert property (&(pad_swdo | ~$past(core_swdo)))
    else $error("pad debug data not from core");
  a_sync_settles: assert property ($stable(gpio_pin_in) [*3]
    |=> core_io_block_in == $past(gpio_pin_in))
    else $error("input register not settled");
endmodule : scb_bank_props

bind scb_bank scb_bank_props #(.IRQ_LINES(IRQ_LINES), .MEM_COUNT(MEM_COUNT)) u_props (
  .mclk, .reset, .apb_req, .apb_rsp, .irq_lines, .nmi_core0, .nmi_core1,
  .core0_debug_instance_id, .core_swdo, .pad_swdo, .gpio_pin_in, .core_io_block_in,
  .memory_power_off);

//--- tb/scb_core_model.sv
// Behavioural model of the two cores: halt state and debug data out.
// Assumes the bank drives each core's debug clock and data in on mclk.
// =====================================================================
// Core model
module scb_core_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] halt_req,
  input wire logic [1:0] core_swclk,
  input wire logic [1:0] core_swdi,
  output logic [1:0] core_halted,
  output logic [1:0] core_swdo
);
  logic [1:0] last_clk;
  logic [1:0] rise;
  assign rise = core_swclk & ~last_clk;
  // A core echoes its debug data in on each rising debug clock.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      core_halted <= 2'h0;
      core_swdo <= 2'h0;
      last_clk <= 2'h3;
    end else begin
      core_halted <= halt_req;
      core_swdo <= (rise & core_swdi) | (~rise & core_swdo);
      last_clk <= core_swclk;
    end
  end
endmodule : scb_core_model

//--- tb/test_system_config_bank.sv
// Self-checking bench of the system configuration bank over APB.
// Assumes the core model stands on the halt and debug side of the bank.
module test_system_config_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import scb_pkg::*;
  localparam logic [31:0] WDAT [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hEE000003,
    32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF};
  localparam logic [31:0] RSTV [8] = '{32'h0, 32'h0, 32'h10000000, 32'h0, 32'h0,
    32'h66, 32'h0, 32'h0};
  localparam logic [31:0] FULL [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hEE000000,
    32'h3FFFFFFF, 32'h3F, 32'h0, 32'hFF, 32'h0};
  logic mclk, reset, nmi0, nmi1;
  scb_apb_req_type req;
  scb_apb_rsp_type rsp;
  logic [31:0] irq, rdata;
  logic [3:0] id0, id1;
  logic [1:0] halt_req, halted, swdo, pclk, pdi, cclk, cdi, pdo;
  logic [35:0] gpio, io;
  logic [7:0] mpo;
  int failures, total_checks;
  scb_bank dut (.mclk(mclk), .reset(reset), .apb_req(req), .apb_rsp(rsp), .irq_lines(irq),
    .nmi_core0(nmi0), .nmi_core1(nmi1), .core0_debug_instance_id(id0),
    .core1_debug_instance_id(id1), .core0_halted(halted[0]), .core1_halted(halted[1]),
    .gpio_pin_in(gpio), .core_io_block_in(io), .pad_swclk(pclk), .pad_swdi(pdi),
    .core_swdo(swdo), .core_swclk(cclk), .core_swdi(cdi), .pad_swdo(pdo),
    .memory_power_off(mpo));
  scb_core_model cores (.mclk(mclk), .reset(reset), .halt_req(halt_req), .core_swclk(cclk),
    .core_swdi(cdi), .core_halted(halted), .core_swdo(swdo));
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    req <= '0;
    @(posedge mclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk({4'h0, rdata}, {4'h0, exp});
  endtask : rd
  task automatic end_sim;
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Watchdog: the whole sequence needs under 150 cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    end_sim;
  end
  // =====================================================================
  // Sequence
  initial begin
    reset = 1'b1;
    req = '0;
    irq = '0;
    halt_req = '0;
    gpio = '0;
    pclk = '0;
    pdi = '0;
    failures = 0;
    total_checks = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) rd(12'(4 * i), RSTV[i]);
    // Detached ports follow the pads and cores one edge after reset ends.
    chk({id1, id0, cclk, cdi, pdo}, 14'h0400);
    for (int i = 0; i < 8; i++) wr(12'(4 * i), WDAT[i]);
    for (int i = 0; i < 8; i++) rd(12'(4 * i), FULL[i]);
    chk({id1, id0, mpo}, 16'hEEFF);
    irq <= 32'h00000020;
    repeat (2) @(posedge mclk);
    chk({nmi1, nmi0}, 2'h3);
    wr(OFF_NMI_MASK0, 32'h00000010);
    @(posedge mclk);
    chk({nmi1, nmi0}, 2'h2);
    irq <= 32'h00000010;
    repeat (2) @(posedge mclk);
    chk({nmi1, nmi0}, 2'h3);
    wr(OFF_MEM_OFF, 32'h00000005);
    @(posedge mclk);
    chk(mpo, 8'h05);
    halt_req <= 2'h2;
    repeat (3) @(posedge mclk);
    rd(OFF_PROC_CFG, 32'hEE000002);
    wr(OFF_SKIP_LOW, 32'h00000001);
    wr(OFF_SKIP_HIGH, 32'h00000001);
    gpio <= 36'h0C0000003;
    repeat (2) @(posedge mclk);
    chk({io[31:30], io[1:0]}, 4'h5);
    @(posedge mclk);
    chk({io[31:30], io[1:0]}, 4'h5);
    @(posedge mclk);
    chk({io[31:30], io[1:0]}, 4'hF);
    wr(OFF_DBG_OVR, 32'h000000A0);
    @(posedge mclk);
    chk({cclk, cdi, pdo}, 6'h0A);
    wr(OFF_DBG_OVR, 32'h000000E0);
    repeat (2) @(posedge mclk);
    rd(OFF_DBG_OVR, 32'h000000F0);
    wr(OFF_DBG_OVR, 32'h0);
    pclk <= 2'h2;
    pdi <= 2'h2;
    repeat (2) @(posedge mclk);
    chk({cclk, pdo}, 4'hA);
    end_sim;
  end
endmodule : test_system_config_bank
